// ===== hw/acs_params.svh
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// acquisition codes
`define ACS_ACQ_MANUAL      3'h0
`define ACS_ACQ_CODE_4TAD   3'h2
// conversion clock codes
`define ACS_CLK_RC_LOW2     2'h3
// bit periods per conversion and gap
`define ACS_CONV_TADS       4'hB
`define ACS_GAP_TADS        5'h02
`define ACS_RESULT_BITS     10
// instruction cycle: 4 ref_clk cycles
`define ACS_INSTR_CYCLES    3'h4
// dedicated rc bit period in ref_clk cycles (1.7 us at 20 ns)
`define ACS_RC_TAD_NS       1700
`define ACS_CLK_PERIOD_NS   20
`define ACS_RC_TAD_CYCLES   ((`ACS_RC_TAD_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

// ===== hw/acs_pkg.sv
package acs_pkg;

    typedef enum logic [2:0] {
        ACS_IDLE,
        ACS_DEFER,
        ACS_ACQ,
        ACS_CONV,
        ACS_GAP
    } acs_state_e;

    // control bits written by software
    typedef struct packed {
        logic       converter_enable;
        logic [2:0] acquisition_time_sel;
        logic [2:0] conversion_clock_sel;
        logic       result_justify_sel;
    } acs_ctrl_s;

    // result pair
    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } acs_result_s;

endpackage

// ===== hw/acs_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

// bit period enable: system clock divided by 2..64, or the dedicated rc rate
module acs_tad_gen (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    // bit period tick
    output logic            tad_tick
);

    logic [6:0] div_q;
    logic [6:0] limit;

    always_comb begin
        case (clk_sel)
            3'h0:    limit = 7'h02;
            3'h4:    limit = 7'h04;
            3'h1:    limit = 7'h08;
            3'h5:    limit = 7'h10;
            3'h2:    limit = 7'h20;
            3'h6:    limit = 7'h40;
            default: limit = 7'(`ACS_RC_TAD_CYCLES);
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !run || div_q >= limit - 7'h01) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    assign tad_tick = run && (div_q == limit - 7'h01);

endmodule

`default_nettype wire

// ===== hw/acs_sequencer.sv
// What this block does
// - converter runs only when enable is one
// - start converts now or after acquisition delay
// - code 010 gives four bit period acquisition
// - start deferred one instruction cycle
// - completion clears busy, sets flag, loads result
// - array discharged after every sample
// - abort during conversion loads partial result, fill last bit
// - reset returns control state, stops conversion
// - two bit period gap before next acquisition
// - idle mode does not stop conversion
// - rc clock adds one instruction wait
// - done in sleep with irq enable wakes
// - no irq enable: power down after sleep conversion
// - non rc clock: sleep aborts, powers down
// - trigger sets busy, resets timer counter
// - conversion takes eleven bit periods
// - acquisition codes two to twenty, 000 manual
// - done flag set regardless of irq enable
// - justify selects left or right result layout
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acs_sequencer (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // software control
    input  wire acs_pkg::acs_ctrl_s   ctrl,
    input  wire logic                 start_set,
    input  wire logic                 busy_clear,
    input  wire logic                 done_flag_clear,
    input  wire logic                 conversion_irq_enable,
    // system state
    input  wire logic                 sleep_mode,
    input  wire logic                 idle_mode,
    input  wire logic                 special_event_trigger,
    // comparator from analog array
    input  wire logic                 cmp_above,
    // status
    output logic                      convert_start_busy,
    output logic                      conversion_done_flag,
    output acs_pkg::acs_result_s      result,
    output logic                      wake_event,
    output logic                      timer_counter_reset,
    // analog side controls
    output logic                      analog_powered,
    output logic                      sample_connect,
    output logic                      array_discharge,
    output logic [9:0]                trial_code
);
    import acs_pkg::*;

    acs_state_e  state_q;
    logic        busy_q;
    logic        done_q;
    logic [9:0]  sar_q;
    logic [3:0]  bit_q;
    logic [4:0]  cnt_q;
    logic [2:0]  instr_q;
    logic        rc_extra_q;
    logic        off_q;
    logic        wake_q;
    logic        trig_q;
    acs_result_s result_q;
    logic        tad_tick;
    logic        is_rc;
    logic        start_req;
    logic        abort;
    logic        finish;
    logic [4:0]  acq_tads;
    logic [9:0]  partial;
    logic [9:0]  res_val;

    assign is_rc     = (ctrl.conversion_clock_sel[1:0] == `ACS_CLK_RC_LOW2);
    assign start_req = (start_set || special_event_trigger) && ctrl.converter_enable;
    assign finish    = (state_q == ACS_CONV) && tad_tick && (bit_q == 4'h0);
    // software clear, enable off or sleep on a system derived clock all abort
    assign abort     = busy_q && (busy_clear || !ctrl.converter_enable || (sleep_mode && !is_rc));

    always_comb begin
        case (ctrl.acquisition_time_sel)
            3'h1:    acq_tads = 5'h02;
            `ACS_ACQ_CODE_4TAD: acq_tads = 5'h04;
            3'h3:    acq_tads = 5'h06;
            3'h4:    acq_tads = 5'h08;
            3'h5:    acq_tads = 5'h0C;
            3'h6:    acq_tads = 5'h10;
            3'h7:    acq_tads = 5'h14;
            default: acq_tads = 5'h00;
        endcase
    end

    acs_tad_gen u_tad (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .run      (state_q == ACS_ACQ || state_q == ACS_CONV || state_q == ACS_GAP),
        .clk_sel  (ctrl.conversion_clock_sel),
        .tad_tick (tad_tick)
    );

    // partial result: unconverted bits copy the last decided bit
    always_comb begin
        partial = sar_q;
        for (int i = 0; i < `ACS_RESULT_BITS; i++) begin
            if (32'(i) <= 32'(bit_q) && bit_q < 4'hA) begin
                partial[i] = (bit_q == 4'h9) ? 1'b0 : sar_q[bit_q + 4'h1];
            end
        end
    end

    // sequencing state; idle mode is ignored on purpose
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q    <= ACS_IDLE;
            cnt_q      <= 5'h00;
            instr_q    <= 3'h0;
            rc_extra_q <= 1'b0;
            bit_q      <= 4'hA;
        end else if (abort) begin
            state_q <= ACS_GAP;
            cnt_q   <= `ACS_GAP_TADS;
        end else begin
            case (state_q)
                ACS_IDLE: begin
                    if (start_req && !off_q) begin
                        state_q    <= ACS_DEFER;
                        instr_q    <= `ACS_INSTR_CYCLES;
                        rc_extra_q <= is_rc;
                    end
                end
                ACS_DEFER: begin
                    if (instr_q == 3'h1) begin
                        if (rc_extra_q) begin
                            rc_extra_q <= 1'b0;
                            instr_q    <= `ACS_INSTR_CYCLES;
                        end else if (acq_tads == 5'h00) begin
                            state_q <= ACS_CONV;
                            bit_q   <= 4'h9;
                            cnt_q   <= 5'h01;
                        end else begin
                            state_q <= ACS_ACQ;
                            cnt_q   <= acq_tads;
                        end
                    end else begin
                        instr_q <= instr_q - 3'h1;
                    end
                end
                ACS_ACQ: begin
                    if (tad_tick) begin
                        if (cnt_q == 5'h01) begin
                            state_q <= ACS_CONV;
                            bit_q   <= 4'h9;
                            cnt_q   <= 5'h01;
                        end else begin
                            cnt_q <= cnt_q - 5'h01;
                        end
                    end
                end
                ACS_CONV: begin
                    // first bit period disconnects and settles, then ten decisions
                    if (tad_tick) begin
                        if (cnt_q != 5'h00) begin
                            cnt_q <= 5'h00;
                        end else if (bit_q == 4'h0) begin
                            state_q <= ACS_GAP;
                            cnt_q   <= `ACS_GAP_TADS;
                            bit_q   <= 4'hA;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                        end
                    end
                end
                ACS_GAP: begin
                    bit_q <= 4'hA;
                    if (tad_tick) begin
                        if (cnt_q == 5'h01) begin
                            state_q <= ACS_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 5'h01;
                        end
                    end
                end
                default: state_q <= ACS_IDLE;
            endcase
        end
    end

    // successive approximation register
    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_q == ACS_DEFER) begin
            sar_q <= 10'h000;
        end else if (state_q == ACS_CONV && tad_tick && cnt_q == 5'h00 && bit_q < 4'hA) begin
            sar_q[bit_q] <= !cmp_above;
        end
    end

    assign trial_code = (state_q == ACS_CONV && bit_q < 4'hA) ? (sar_q | (10'h001 << bit_q)) : sar_q;

    // busy bit
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (start_req && state_q == ACS_IDLE && !off_q) begin
            busy_q <= 1'b1;
        end else if (finish || abort) begin
            busy_q <= 1'b0;
        end
    end

    // done flag: set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else if (finish && !abort) begin
            done_q <= 1'b1;
        end else if (done_flag_clear) begin
            done_q <= 1'b0;
        end
    end

    // an abort on the last bit period still loads the partial value
    assign res_val = (finish && !abort) ? {sar_q[9:1], !cmp_above} : partial;

    // result registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            result_q <= '0;
        end else if ((finish && !abort) || (abort && state_q == ACS_CONV)) begin
            if (ctrl.result_justify_sel) begin
                result_q <= {6'h00, res_val[9:8], res_val[7:0]};
            end else begin
                result_q <= {res_val[9:2], res_val[1:0], 6'h00};
            end
        end
    end

    // sleep handling: wake pulse or power down with enable still set
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !sleep_mode) begin
            off_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= finish && conversion_irq_enable;
            if ((finish && !conversion_irq_enable) || abort) begin
                off_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= special_event_trigger;
        end
    end

    assign convert_start_busy   = busy_q;
    assign conversion_done_flag = done_q;
    assign result               = result_q;
    assign wake_event           = wake_q;
    assign timer_counter_reset  = trig_q;
    assign analog_powered       = ctrl.converter_enable && !off_q;
    assign sample_connect       = analog_powered && (state_q == ACS_IDLE || state_q == ACS_DEFER || state_q == ACS_ACQ);
    assign array_discharge      = (state_q == ACS_GAP);

    busy_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == ACS_CONV || state_q == ACS_ACQ) |-> busy_q) else $error("busy low mid conversion");
    done_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (finish && !abort) |=> (done_q && !busy_q)) else $error("completion not flagged");
    enable_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!ctrl.converter_enable && state_q == ACS_IDLE) |=> state_q == ACS_IDLE) else $error("ran while off");
    defer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == ACS_IDLE && $past(state_q) == ACS_IDLE && start_req && !off_q && !is_rc && !abort)
        |=> (state_q == ACS_DEFER) [*4]) else $error("defer wrong length");
    gap_after_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == ACS_CONV && $past(state_q) == ACS_CONV && !abort && finish) |=> state_q == ACS_GAP)
        else $error("no gap after conversion");
    abort_stop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        abort |=> (!busy_q && state_q == ACS_GAP)) else $error("abort ignored");
    discharge_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_q == ACS_GAP) |-> (array_discharge && !sample_connect)) else $error("no discharge");
    trig_timer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        special_event_trigger |=> timer_counter_reset) else $error("timer not reset");
    idle_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (idle_mode && state_q == ACS_CONV && !abort && !finish) |=> state_q == ACS_CONV)
        else $error("idle stopped conversion");
    sleep_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (sleep_mode && !is_rc && busy_q && !busy_clear) |=> (!busy_q && ctrl.converter_enable |-> !analog_powered))
        else $error("sleep did not abort");

    conv_done_c: cover property (@(posedge ref_clk) finish && !abort);
    abort_c: cover property (@(posedge ref_clk) abort && state_q == ACS_CONV);
    acq_c: cover property (@(posedge ref_clk) state_q == ACS_ACQ && tad_tick);
    wake_c: cover property (@(posedge ref_clk) wake_q);

endmodule

`default_nettype wire

// ===== tb/acs_sar_model.sv
`timescale 1ns/1ps
`default_nettype none

// behavioural hold capacitor and comparator facing the sequencer
module acs_sar_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // analog input level and controls
    input  wire logic [9:0] vin,
    input  wire logic       analog_powered,
    input  wire logic       sample_connect,
    input  wire logic [9:0] trial_code,
    // decision
    output logic            cmp_above
);
    logic [9:0] held_q;
    logic       junk_q;

    // unpowered comparator gives a changing, meaningless level
    always_ff @(posedge ref_clk) begin
        junk_q <= sys_rst ? 1'b0 : ~junk_q;
        if (sys_rst)
            held_q <= 10'h000;
        else if (sample_connect)
            held_q <= vin;
    end

    assign cmp_above = analog_powered ? (held_q < trial_code) : junk_q;
endmodule

`default_nettype wire

// ===== tb/acs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer_tb_top;
    import acs_pkg::*;

    logic ref_clk, sys_rst, start_set, busy_clear, done_flag_clear, conversion_irq_enable;
    logic sleep_mode, idle_mode, special_event_trigger, cmp_above, busy, done, wake, tmr_rst;
    logic analog_powered, sample_connect, array_discharge, woke;
    logic [9:0]  trial_code, vin;
    acs_ctrl_s   ctrl;
    acs_result_s result;
    int          miscompares, cmp_count, n;

    acs_sequencer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ctrl(ctrl), .start_set(start_set),
        .busy_clear(busy_clear), .done_flag_clear(done_flag_clear),
        .conversion_irq_enable(conversion_irq_enable), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .special_event_trigger(special_event_trigger), .cmp_above(cmp_above),
        .convert_start_busy(busy), .conversion_done_flag(done), .result(result), .wake_event(wake),
        .timer_counter_reset(tmr_rst), .analog_powered(analog_powered),
        .sample_connect(sample_connect), .array_discharge(array_discharge), .trial_code(trial_code));

    acs_sar_model i_sar (.ref_clk(ref_clk), .sys_rst(sys_rst), .vin(vin), .analog_powered(analog_powered),
        .sample_connect(sample_connect), .trial_code(trial_code), .cmp_above(cmp_above));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic [15:0] fmt(input logic [9:0] v, input logic rj);
        fmt = rj ? {6'h00, v} : {v, 6'h00};
    endfunction

    // partial result: top k bits kept, the rest copy the last decided bit
    function automatic logic fill_ok(input logic [9:0] r, input logic [9:0] v);
        fill_ok = 1'b0;
        for (int k = 1; k <= 10; k++)
            if (r === (((v >> (10 - k)) << (10 - k)) | ({10{v[10 - k]}} >> k))) fill_ok = 1'b1;
    endfunction

    task automatic setup(input logic [2:0] acq, input logic [2:0] cs, input logic rj, input logic [9:0] v);
        @(posedge ref_clk);
        ctrl <= '{1'b1, acq, cs, rj};
        vin <= v;
        done_flag_clear <= 1'b1;
        @(posedge ref_clk);
        done_flag_clear <= 1'b0;
        tick(4);
    endtask

    // start by software or by the hardware trigger, back one ns after the answer edge
    task automatic start(input logic hw);
        @(posedge ref_clk);
        if (hw) special_event_trigger <= 1'b1;
        else start_set <= 1'b1;
        @(posedge ref_clk);
        special_event_trigger <= 1'b0;
        start_set <= 1'b0;
        #1;
        woke = tmr_rst;
    endtask

    task automatic wait_done(input int lo, input int hi);
        n = 0;
        woke = 1'b0;
        while (busy === 1'b1 && n < 1200) begin
            tick(1);
            n++;
            if (wake === 1'b1) woke = 1'b1;
        end
        check({15'h0, n >= lo && n <= hi}, 16'h1);
        tick(1);
    endtask

    task automatic t_plain();
        setup(3'h0, 3'h0, 1'b1, 10'h2A5);
        start(1'b0);
        check({15'h0, busy}, 16'h1);
        wait_done(26, 30);
        check({15'h0, done}, 16'h1);
        check(result, fmt(10'h2A5, 1'b1));
        start(1'b0);
        check({14'h0, busy, array_discharge}, 16'h1);
        tick(8);
        start(1'b0);
        check({15'h0, busy}, 16'h1);
        wait_done(26, 30);
        $display("test plain done");
    endtask

    task automatic t_acq4_idle();
        setup(3'h2, 3'h0, 1'b0, 10'h155);
        @(posedge ref_clk);
        idle_mode <= 1'b1;
        start(1'b0);
        wait_done(34, 38);
        check(result, fmt(10'h155, 1'b0));
        @(posedge ref_clk);
        idle_mode <= 1'b0;
        ctrl.converter_enable <= 1'b0;
        tick(8);
        start(1'b0);
        check({15'h0, busy}, 16'h0);
        $display("test acq4 idle done");
    endtask

    task automatic t_abort_trig();
        setup(3'h0, 3'h0, 1'b1, 10'h2EA);
        start(1'b0);
        tick(13);
        @(posedge ref_clk);
        busy_clear <= 1'b1;
        @(posedge ref_clk);
        busy_clear <= 1'b0;
        tick(2);
        check({15'h0, busy}, 16'h0);
        check({15'h0, fill_ok(result[9:0], 10'h2EA)}, 16'h1);
        check(result, fmt(10'h2FF, 1'b1));
        tick(10);
        start(1'b1);
        check({14'h0, busy, woke | tmr_rst}, 16'h3);
        wait_done(26, 30);
        $display("test abort trigger done");
    endtask

    task automatic t_sleep();
        setup(3'h0, 3'h0, 1'b1, 10'h0F0);
        start(1'b0);
        tick(9);
        @(posedge ref_clk);
        sleep_mode <= 1'b1;
        tick(3);
        check({14'h0, busy, analog_powered}, 16'h0);
        @(posedge ref_clk);
        sleep_mode <= 1'b0;
        for (int irq = 1; irq >= 0; irq--) begin
            setup(3'h0, 3'h3, 1'b1, 10'h0F0);
            @(posedge ref_clk);
            conversion_irq_enable <= irq[0];
            sleep_mode <= 1'b1;
            start(1'b0);
            wait_done(943, 947);
            check({14'h0, done, woke}, {14'h0, 1'b1, irq[0]});
            check(result, fmt(10'h0F0, 1'b1));
            if (irq == 0) check({15'h0, analog_powered}, 16'h0);
            @(posedge ref_clk);
            sleep_mode <= 1'b0;
            tick(200);
        end
        $display("test sleep done");
    endtask

    task automatic t_reset();
        setup(3'h0, 3'h0, 1'b1, 10'h3C3);
        start(1'b0);
        wait_done(26, 30);
        tick(4);
        start(1'b0);
        tick(7);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        check({14'h0, busy, done}, 16'h0);
        check(result, 16'h0000);
        start(1'b0);
        check({15'h0, busy}, 16'h1);
        $display("test reset done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        {sys_rst, start_set, busy_clear, done_flag_clear, conversion_irq_enable} = 5'h10;
        {sleep_mode, idle_mode, special_event_trigger} = 3'h0;
        ctrl = '0;
        vin = 10'h000;
        miscompares = 0;
        cmp_count = 0;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_plain();
        t_acq4_idle();
        t_abort_trig();
        t_sleep();
        t_reset();
        print_verdict();
    end

    // the whole run needs about 3000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
endmodule

`default_nettype wire
